// file: icl_defines.svh
// constants for the internal contact logic combiner
// assumes inclusion by bare name from the package and the design modules
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH

`define ICL_SEL_W          6
`define ICL_FUNC_W         3
`define ICL_NUM_CONTACTS   3
`define ICL_NUM_EVENTS     5
`define ICL_NUM_EVT_OUT    3

`define ICL_SEL_OFF        6'h00
`define ICL_SEL_ON         6'h01
`define ICL_SEL_DIG1       6'h02
`define ICL_SEL_DIG2       6'h03
`define ICL_SEL_EVT1       6'h0A
`define ICL_SEL_EVT5       6'h0E
`define ICL_SEL_COMM1      6'h12
`define ICL_SEL_COMM4      6'h15
`define ICL_SEL_MANUAL     6'h16
`define ICL_SEL_READY      6'h17
`define ICL_SEL_ATUNE      6'h19
`define ICL_SEL_RAMP       6'h1A
`define ICL_SEL_ALARM      6'h1C
`define ICL_SEL_PVALARM    6'h1D
`define ICL_SEL_MODEKEY    6'h1F
`define ICL_SEL_EVOUT1     6'h20
`define ICL_SEL_CTLOUT1    6'h21

`define ICL_FUNC_DEFAULT   3'h0
`define ICL_FUNC_AB_OR_CD  3'h1
`define ICL_FUNC_AORB_AND  3'h2
`define ICL_FUNC_ANY       3'h3
`define ICL_FUNC_ALL       3'h4

`define ICL_RST_SEL_A1     6'h02
`define ICL_RST_SEL_A2     6'h03
`define ICL_RST_SEL_A3     6'h04
`define ICL_RST_SEL_BCD    6'h00
`define ICL_RST_INPOL      4'h0
`define ICL_RST_OUTPOL     1'h0
`define ICL_RST_FUNC       3'h0

// default output assignment: event n drives event output n, code 0 means none
`define ICL_ASSIGN_W       3
`define ICL_RST_ASSIGN1    3'h1
`define ICL_RST_ASSIGN2    3'h2
`define ICL_RST_ASSIGN3    3'h3
`endif

// file: icl_pkg.sv
// types shared by the internal contact logic combiner files
// assumes icl_defines.svh is reachable by bare name
`include "icl_defines.svh"

package icl_pkg;

	// every source a selector may pick from
	typedef struct packed {
		logic [1:0]                 dig_in;
		logic [`ICL_NUM_EVENTS-1:0] evt;
		logic [3:0]                 comm_in;
		logic                       manual_mode;
		logic                       ready_mode;
		logic                       auto_tuning;
		logic                       setpoint_ramp;
		logic                       any_alarm;
		logic                       process_value_alarm;
		logic                       mode_key;
		logic                       evt_out1;
		logic                       ctl_out1;
	} icl_src_type;

	// one contact's configuration
	typedef struct packed {
		logic [`ICL_FUNC_W-1:0] func;
		logic [`ICL_SEL_W-1:0]  sel_d;
		logic [`ICL_SEL_W-1:0]  sel_c;
		logic [`ICL_SEL_W-1:0]  sel_b;
		logic [`ICL_SEL_W-1:0]  sel_a;
		logic [3:0]             in_pol;
		logic                   out_pol;
	} icl_cfg_type;

	typedef enum logic [1:0] {
		ICL_WR_IDLE  = 2'h0,
		ICL_WR_APPLY = 2'h1
	} icl_wr_state_type;

endpackage

// file: icl_contact.sv
// one internal contact: four selectors, polarity, combining function
// assumes sources and configuration are already on the core clock
`timescale 1ns/10ps
`include "icl_defines.svh"

module icl_contact (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset,
	input  wire logic                   i_ce,
	input  wire logic [1:0]             i_index,
	input  wire icl_pkg::icl_src_type   i_src,
	input  wire icl_pkg::icl_cfg_type   i_cfg,
	output logic                        o_contact
);

	typedef struct packed {
		logic contact;
	} icl_contact_state_type;

	icl_contact_state_type state_reg;
	icl_contact_state_type state_next;

	function automatic logic pick(input logic [`ICL_SEL_W-1:0] code,
		input icl_pkg::icl_src_type s);
		logic r;
		r = 1'b0;
		case (code)
			`ICL_SEL_OFF:     r = 1'b0;
			`ICL_SEL_ON:      r = 1'b1;
			`ICL_SEL_DIG1:    r = s.dig_in[0];
			`ICL_SEL_DIG2:    r = s.dig_in[1];
			`ICL_SEL_MANUAL:  r = s.manual_mode;
			`ICL_SEL_READY:   r = s.ready_mode;
			`ICL_SEL_ATUNE:   r = s.auto_tuning;
			`ICL_SEL_RAMP:    r = s.setpoint_ramp;
			`ICL_SEL_ALARM:   r = s.any_alarm;
			`ICL_SEL_PVALARM: r = s.process_value_alarm;
			`ICL_SEL_MODEKEY: r = s.mode_key;
			`ICL_SEL_EVOUT1:  r = s.evt_out1;
			`ICL_SEL_CTLOUT1: r = s.ctl_out1;
			default: begin
				// undefined codes read as off
				if (code >= `ICL_SEL_EVT1 && code <= `ICL_SEL_EVT5) begin
					r = s.evt[3'(code - `ICL_SEL_EVT1)];
				end else if (code >= `ICL_SEL_COMM1 && code <= `ICL_SEL_COMM4) begin
					r = s.comm_in[2'(code - `ICL_SEL_COMM1)];
				end
			end
		endcase
		return r;
	endfunction

	logic [3:0] bits;
	logic       comb;

	always_comb begin
		state_next = state_reg;
		bits = {pick(i_cfg.sel_d, i_src), pick(i_cfg.sel_c, i_src),
			pick(i_cfg.sel_b, i_src), pick(i_cfg.sel_a, i_src)} ^ i_cfg.in_pol;
		case (i_cfg.func)
			`ICL_FUNC_AB_OR_CD: comb = (bits[0] & bits[1]) | (bits[2] & bits[3]);
			`ICL_FUNC_AORB_AND: comb = (bits[0] | bits[1]) & (bits[2] | bits[3]);
			`ICL_FUNC_ANY:      comb = |bits;
			`ICL_FUNC_ALL:      comb = &bits;
			default:            comb = 1'b0;
		endcase
		if (i_cfg.func == `ICL_FUNC_DEFAULT) begin
			// default input bypasses both polarities
			case (i_index)
				2'h0:    state_next.contact = i_src.dig_in[0];
				2'h1:    state_next.contact = i_src.dig_in[1];
				default: state_next.contact = 1'b0;
			endcase
		end else begin
			state_next.contact = comb ^ i_cfg.out_pol;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg <= '0;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	assign o_contact = state_reg.contact;

endmodule

// file: icl_do_assign.sv
// digital output assignment: routes internal events to event outputs
// assumes events arrive on the core clock
`timescale 1ns/10ps
`include "icl_defines.svh"

module icl_do_assign (
	input  wire logic                                       i_core_clk,
	input  wire logic                                       i_reset,
	input  wire logic                                       i_ce,
	input  wire logic [`ICL_NUM_EVENTS-1:0]                 i_evt,
	input  wire logic [`ICL_NUM_EVT_OUT*`ICL_ASSIGN_W-1:0]  i_assign,
	input  wire logic [`ICL_NUM_EVT_OUT-1:0]                i_fitted,
	output logic      [`ICL_NUM_EVT_OUT-1:0]                o_evt_out
);

	typedef struct packed {
		logic [`ICL_NUM_EVT_OUT-1:0] out;
	} icl_do_state_type;

	icl_do_state_type state_reg;
	icl_do_state_type state_next;

	always_comb begin
		logic [`ICL_ASSIGN_W-1:0] a;
		a = '0;
		state_next = state_reg;
		for (int k = 0; k < `ICL_NUM_EVT_OUT; k++) begin
			a = i_assign[k*`ICL_ASSIGN_W +: `ICL_ASSIGN_W];
			// only path from events to outputs; unfitted outputs stay off
			if (a != '0 && a <= 3'(`ICL_NUM_EVENTS) && i_fitted[k]) begin
				state_next.out[k] = i_evt[3'(a - 3'h1)];
			end else begin
				state_next.out[k] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg <= '0;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	assign o_evt_out = state_reg.out;

endmodule

// file: icl_combiner.sv
// internal contact logic combiner top: configuration store, input sync, contacts, event outputs
// assumes pins are asynchronous, configuration writes come from same-clock logic
//
// Operation
// - each of three contacts has four selectors A to D feeding its combining function.
// - code 0 gives off, 1 on, 2 first digital input, 3 second, 4 to 9 read as off.
// - codes 10 to 14 pick internal events 1 to 5, 15 to 17 read as off.
// - codes 18 to 21 pick comm inputs 1 to 4, 22 manual mode, 23 ready mode, 24 off.
// - 25 auto tuning, 26 setpoint ramp, 28 any alarm, 29 process value alarm, 27 off.
// - 31 mode key, 32 event output 1, 33 control output 1, 30 off.
// - after reset selector A holds 2, 3, 4 for contacts 1 to 3 and the rest hold 0.
// - selectors and input polarity are readable and writable only when function is 1 to 4.
// - a four-bit input polarity, bit 0 for A up to bit 3 for D, 1 inverts, reset 0000.
// - an output polarity inverts the combined result when 1, reset 0.
// - five internal events exist while only zero to three event outputs are fitted.
// - events reach outputs only through the output assignment stage.
// - by default events 1 to 3 drive event outputs 1 to 3; 4 and 5 need assignment.
// - function 1 is AB or CD, 2 is (A or B) and (C or D), 3 any, 4 all.
// - function 0 makes contact 1 follow input 1, contact 2 input 2, contact 3 off.
`timescale 1ns/10ps
`include "icl_defines.svh"

module icl_combiner (
	input  wire logic                                      i_core_clk,
	input  wire logic                                      i_reset,
	input  wire logic                                      i_ce,
	// physical pins, asynchronous
	input  wire logic [1:0]                                i_digital_input_line,
	input  wire logic                                      i_mode_key,
	// same-clock controller state
	input  wire logic [`ICL_NUM_EVENTS-1:0]                i_evt,
	input  wire logic [3:0]                                i_comm_in,
	input  wire logic                                      i_manual_mode,
	input  wire logic                                      i_ready_mode,
	input  wire logic                                      i_auto_tuning,
	input  wire logic                                      i_setpoint_ramp,
	input  wire logic                                      i_any_alarm,
	input  wire logic                                      i_process_value_alarm,
	input  wire logic                                      i_ctl_out1,
	input  wire logic [`ICL_NUM_EVT_OUT-1:0]               i_evt_out_fitted,
	// configuration write port
	input  wire logic                                      i_cfg_wr,
	input  wire logic [1:0]                                i_cfg_contact,
	input  wire icl_pkg::icl_cfg_type                      i_cfg_data,
	input  wire logic                                      i_assign_wr,
	input  wire logic [`ICL_NUM_EVT_OUT*`ICL_ASSIGN_W-1:0] i_assign_data,
	// configuration readback for the selected contact
	output icl_pkg::icl_cfg_type                           o_cfg_view,
	output logic                                           o_cfg_visible,
	output logic [`ICL_NUM_CONTACTS-1:0]                   o_contact,
	output logic [`ICL_NUM_EVT_OUT-1:0]                    o_evt_out
);

	typedef struct packed {
		logic [1:0]                                dig_meta;
		logic [1:0]                                dig_sync;
		logic                                      key_meta;
		logic                                      key_sync;
		icl_pkg::icl_cfg_type                      cfg0;
		icl_pkg::icl_cfg_type                      cfg1;
		icl_pkg::icl_cfg_type                      cfg2;
		logic [`ICL_NUM_EVT_OUT*`ICL_ASSIGN_W-1:0] assign_map;
		icl_pkg::icl_cfg_type                      view;
		logic                                      visible;
	} icl_top_state_type;

	icl_top_state_type state_reg;
	icl_top_state_type state_next;

	function automatic icl_pkg::icl_cfg_type reset_cfg(input logic [`ICL_SEL_W-1:0] sel_a);
		icl_pkg::icl_cfg_type c;
		c.func    = `ICL_RST_FUNC;
		c.sel_a   = sel_a;
		c.sel_b   = `ICL_RST_SEL_BCD;
		c.sel_c   = `ICL_RST_SEL_BCD;
		c.sel_d   = `ICL_RST_SEL_BCD;
		c.in_pol  = `ICL_RST_INPOL;
		c.out_pol = `ICL_RST_OUTPOL;
		return c;
	endfunction

	// selector fields only change when the newly written function is 1 to 4
	function automatic icl_pkg::icl_cfg_type write_cfg(input icl_pkg::icl_cfg_type old_c,
		input icl_pkg::icl_cfg_type new_c);
		icl_pkg::icl_cfg_type c;
		c = old_c;
		c.func    = new_c.func;
		c.out_pol = new_c.out_pol;
		if (new_c.func != `ICL_FUNC_DEFAULT && new_c.func <= `ICL_FUNC_ALL) begin
			c.sel_a  = new_c.sel_a;
			c.sel_b  = new_c.sel_b;
			c.sel_c  = new_c.sel_c;
			c.sel_d  = new_c.sel_d;
			c.in_pol = new_c.in_pol;
		end
		return c;
	endfunction

	function automatic logic shown(input icl_pkg::icl_cfg_type c);
		return c.func != `ICL_FUNC_DEFAULT && c.func <= `ICL_FUNC_ALL;
	endfunction

	icl_pkg::icl_cfg_type sel_cfg;
	icl_pkg::icl_src_type src;
	logic [`ICL_NUM_EVT_OUT-1:0] evt_out_int;

	always_comb begin
		state_next = state_reg;
		state_next.dig_meta = i_digital_input_line;
		state_next.dig_sync = state_reg.dig_meta;
		state_next.key_meta = i_mode_key;
		state_next.key_sync = state_reg.key_meta;
		if (i_cfg_wr) begin
			case (i_cfg_contact)
				2'h0:    state_next.cfg0 = write_cfg(state_reg.cfg0, i_cfg_data);
				2'h1:    state_next.cfg1 = write_cfg(state_reg.cfg1, i_cfg_data);
				2'h2:    state_next.cfg2 = write_cfg(state_reg.cfg2, i_cfg_data);
				default: state_next.cfg0 = state_reg.cfg0;
			endcase
		end
		if (i_assign_wr) begin
			state_next.assign_map = i_assign_data;
		end
		case (i_cfg_contact)
			2'h1:    sel_cfg = state_reg.cfg1;
			2'h2:    sel_cfg = state_reg.cfg2;
			default: sel_cfg = state_reg.cfg0;
		endcase
		// hidden fields read as zero so software cannot see stale selectors
		state_next.visible = shown(sel_cfg);
		state_next.view    = sel_cfg;
		if (!shown(sel_cfg)) begin
			state_next.view.sel_a  = '0;
			state_next.view.sel_b  = '0;
			state_next.view.sel_c  = '0;
			state_next.view.sel_d  = '0;
			state_next.view.in_pol = '0;
		end
		src.dig_in              = state_reg.dig_sync;
		src.evt                 = i_evt;
		src.comm_in             = i_comm_in;
		src.manual_mode         = i_manual_mode;
		src.ready_mode          = i_ready_mode;
		src.auto_tuning         = i_auto_tuning;
		src.setpoint_ramp       = i_setpoint_ramp;
		src.any_alarm           = i_any_alarm;
		src.process_value_alarm = i_process_value_alarm;
		src.mode_key            = state_reg.key_sync;
		src.evt_out1            = evt_out_int[0];
		src.ctl_out1            = i_ctl_out1;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg.dig_meta   <= '0;
			state_reg.dig_sync   <= '0;
			state_reg.key_meta   <= 1'b0;
			state_reg.key_sync   <= 1'b0;
			state_reg.cfg0       <= reset_cfg(`ICL_RST_SEL_A1);
			state_reg.cfg1       <= reset_cfg(`ICL_RST_SEL_A2);
			state_reg.cfg2       <= reset_cfg(`ICL_RST_SEL_A3);
			state_reg.assign_map <= {`ICL_RST_ASSIGN3, `ICL_RST_ASSIGN2,
				`ICL_RST_ASSIGN1};
			state_reg.view       <= '0;
			state_reg.visible    <= 1'b0;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	icl_contact u_contact0 (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.i_index    (2'h0),
		.i_src      (src),
		.i_cfg      (state_reg.cfg0),
		.o_contact  (o_contact[0])
	);

	icl_contact u_contact1 (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.i_index    (2'h1),
		.i_src      (src),
		.i_cfg      (state_reg.cfg1),
		.o_contact  (o_contact[1])
	);

	icl_contact u_contact2 (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.i_index    (2'h2),
		.i_src      (src),
		.i_cfg      (state_reg.cfg2),
		.o_contact  (o_contact[2])
	);

	// event output 1 feeds back as a selector source; it is registered, so no loop
	icl_do_assign u_do_assign (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.i_evt      (i_evt),
		.i_assign   (state_reg.assign_map),
		.i_fitted   (i_evt_out_fitted),
		.o_evt_out  (evt_out_int)
	);

	assign o_evt_out     = evt_out_int;
	assign o_cfg_view    = state_reg.view;
	assign o_cfg_visible = state_reg.visible;

endmodule

// file: icl_combiner_chk.sv
// concurrent checks on the ports of the internal contact logic combiner
// assumes a single core clock and a synchronous active high reset
`timescale 1ns/10ps
`include "icl_defines.svh"
module icl_combiner_chk (
	input wire logic                                  i_core_clk,
	input wire logic                                  i_reset,
	input wire logic                                  i_ce,
	input wire logic [1:0]                            i_digital_input_line,
	input wire logic [`ICL_NUM_EVENTS-1:0]            i_evt,
	input wire logic [`ICL_NUM_EVT_OUT-1:0]           i_evt_out_fitted,
	input wire logic                                  i_cfg_wr,
	input wire logic [1:0]                            i_cfg_contact,
	input wire icl_pkg::icl_cfg_type                  i_cfg_data,
	input wire logic                                  i_assign_wr,
	input wire icl_pkg::icl_cfg_type                  o_cfg_view,
	input wire logic                                  o_cfg_visible,
	input wire logic [`ICL_NUM_CONTACTS-1:0]          o_contact,
	input wire logic [`ICL_NUM_EVT_OUT-1:0]           o_evt_out
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	// mirror of stored functions only; selectors are checked by the bench model
	logic [2:0] fn_reg [3];
	logic       asg_reg;
	logic [2:0] sel_fn;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			fn_reg <= '{3'h0, 3'h0, 3'h0};
			asg_reg <= 1'b0;
		end else if (i_ce) begin
			if (i_cfg_wr && i_cfg_contact != 2'h3) begin
				fn_reg[i_cfg_contact] <= i_cfg_data.func;
			end
			if (i_assign_wr) begin
				asg_reg <= 1'b1;
			end
		end
	end
	always_comb begin
		sel_fn = (i_cfg_contact == 2'h3) ? 3'h0 : fn_reg[i_cfg_contact];
	end
	sequence s_dflt;
		i_ce && fn_reg[0] == 3'h0;
	endsequence
	a_reset_outputs_clear: assert property ($fell(i_reset) |-> o_contact == 3'h0 &&
		o_evt_out == 3'h0 && o_cfg_view == '0 && !o_cfg_visible) else $error("not clear after reset");
	a_evt_default_map: assert property (i_ce && !asg_reg && !i_assign_wr |=>
		o_evt_out == ($past(i_evt[2:0]) & $past(i_evt_out_fitted))) else $error("default map wrong");
	a_evt_unfitted_low: assert property (i_ce |=>
		(o_evt_out & ~$past(i_evt_out_fitted)) == 3'h0) else $error("unfitted output driven");
	a_contact3_default_off: assert property (i_ce && fn_reg[2] == 3'h0 |=> !o_contact[2])
		else $error("contact 3 not off");
	a_default_follow: assert property (s_dflt ##1 s_dflt ##1 s_dflt |=>
		o_contact[0] == $past(i_digital_input_line[0], 3)) else $error("contact 1 not following");
	a_cfg_visible_func: assert property (i_ce && i_cfg_contact != 2'h3 |=>
		o_cfg_visible == ($past(sel_fn) != 3'h0 && $past(sel_fn) <= 3'h4)) else $error("visible wrong");
	a_view_func_shown: assert property (i_ce && i_cfg_contact != 2'h3 |=>
		o_cfg_view.func == $past(sel_fn)) else $error("viewed function wrong");
	a_hidden_sel_zero: assert property (!o_cfg_visible |-> {o_cfg_view.sel_d, o_cfg_view.sel_c,
		o_cfg_view.sel_b, o_cfg_view.sel_a, o_cfg_view.in_pol} == 28'h0) else $error("hidden shown");
	cover property (o_contact[0] && fn_reg[0] == 3'h4);
	cover property (asg_reg && o_evt_out != 3'h0);
	cover property (o_cfg_visible && o_cfg_view.in_pol != 4'h0);
endmodule
bind icl_combiner icl_combiner_chk chk_u (.i_core_clk, .i_reset, .i_ce, .i_digital_input_line,
	.i_evt, .i_evt_out_fitted, .i_cfg_wr, .i_cfg_contact, .i_cfg_data, .i_assign_wr, .o_cfg_view,
	.o_cfg_visible, .o_contact, .o_evt_out);

// file: icl_combiner_test.sv
// self-checking bench for the internal contact logic combiner
// assumes inputs settle well within five cycles; model compared after settling
`timescale 1ns/10ps
module icl_combiner_test;
	logic i_core_clk, i_reset, i_ce, i_mode_key, i_manual_mode, i_ready_mode, i_auto_tuning;
	logic i_setpoint_ramp, i_any_alarm, i_process_value_alarm, i_ctl_out1, i_cfg_wr, i_assign_wr;
	logic [1:0] i_digital_input_line, i_cfg_contact;
	logic [4:0] i_evt;
	logic [3:0] i_comm_in;
	logic [2:0] i_evt_out_fitted, o_contact, o_evt_out;
	logic [8:0] i_assign_data;
	logic       o_cfg_visible;
	logic [2:0] hold_c, hold_e;
	icl_pkg::icl_cfg_type i_cfg_data, o_cfg_view;
	icl_pkg::icl_cfg_type m_cfg [3];
	int m_map [3];
	int n_errors = 0;
	int n_compared = 0;
	icl_combiner dut_u (.i_core_clk, .i_reset, .i_ce, .i_digital_input_line, .i_mode_key, .i_evt,
		.i_comm_in, .i_manual_mode, .i_ready_mode, .i_auto_tuning, .i_setpoint_ramp, .i_any_alarm,
		.i_process_value_alarm, .i_ctl_out1, .i_evt_out_fitted, .i_cfg_wr, .i_cfg_contact,
		.i_cfg_data, .i_assign_wr, .i_assign_data, .o_cfg_view, .o_cfg_visible, .o_contact,
		.o_evt_out);
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic [2:0] exp_eo();
		logic [2:0] r;
		for (int k = 0; k < 3; k++)
			r[k] = (m_map[k] inside {[1:5]}) ? i_evt[m_map[k]-1] : 1'b0;
		return r & i_evt_out_fitted;
	endfunction
	function automatic logic src_bit(input int c);
		case (c)
			1: return 1'b1;
			2, 3: return i_digital_input_line[c-2];
			10, 11, 12, 13, 14: return i_evt[c-10];
			18, 19, 20, 21: return i_comm_in[c-18];
			22: return i_manual_mode;
			23: return i_ready_mode;
			25: return i_auto_tuning;
			26: return i_setpoint_ramp;
			28: return i_any_alarm;
			29: return i_process_value_alarm;
			31: return i_mode_key;
			32: return |(exp_eo() & 3'h1);
			33: return i_ctl_out1;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic exp_con(input int k);
		icl_pkg::icl_cfg_type c;
		logic [3:0] b;
		logic r;
		c = m_cfg[k];
		if (c.func == 3'h0)
			return (k < 2) ? i_digital_input_line[k] : 1'b0;
		b = {src_bit(c.sel_d), src_bit(c.sel_c), src_bit(c.sel_b), src_bit(c.sel_a)} ^ c.in_pol;
		case (c.func)
			3'h1: r = (b[0] & b[1]) | (b[2] & b[3]);
			3'h2: r = (b[0] | b[1]) & (b[2] | b[3]);
			3'h3: r = |b;
			3'h4: r = &b;
			default: r = 1'b0;
		endcase
		return r ^ c.out_pol;
	endfunction
	task automatic reset_model();
		for (int k = 0; k < 3; k++) begin
			m_cfg[k] = {3'h0, 18'h0, 6'(k + 2), 4'h0, 1'h0};
			m_map[k] = k + 1;
		end
	endtask
	task automatic rnd_src();
		{i_digital_input_line, i_mode_key, i_evt, i_comm_in, i_manual_mode, i_ready_mode,
			i_auto_tuning, i_setpoint_ramp, i_any_alarm, i_process_value_alarm, i_ctl_out1,
			i_evt_out_fitted} = 22'($urandom);
	endtask
	// leaves the strobe high so writes can run back to back; check_all lowers it
	task automatic wr_cfg(input logic [1:0] k, input icl_pkg::icl_cfg_type d);
		i_cfg_contact = k;
		i_cfg_data = d;
		i_cfg_wr = 1'b1;
		@(negedge i_core_clk);
		if (k != 2'h3) begin
			if (d.func == 3'h0 || d.func > 3'h4)
				d = icl_pkg::icl_cfg_type'((m_cfg[k] & 32'h1FFFFFFE) | (d & 32'hE0000001));
			m_cfg[k] = d;
		end
	endtask
	task automatic check_all();
		icl_pkg::icl_cfg_type v;
		i_cfg_wr = 1'b0;
		repeat (5) @(negedge i_core_clk);
		cmp(o_contact, {exp_con(2), exp_con(1), exp_con(0)}, "contact");
		cmp(o_evt_out, exp_eo(), "event out");
		for (int k = 0; k < 3; k++) begin
			i_cfg_contact = 2'(k);
			@(negedge i_core_clk);
			v = m_cfg[k];
			if (v.func == 3'h0 || v.func > 3'h4)
				v = icl_pkg::icl_cfg_type'(v & 32'hE0000001);
			cmp(o_cfg_visible, v.func inside {[3'h1:3'h4]}, "visible");
			cmp(o_cfg_view, v, "view");
		end
	endtask
	function automatic icl_pkg::icl_cfg_type rnd_cfg();
		icl_pkg::icl_cfg_type d;
		d = icl_pkg::icl_cfg_type'(32'($urandom));
		d.func = 3'($urandom_range(7));
		{d.sel_d, d.sel_c} = {6'($urandom_range(33)), 6'($urandom_range(33))};
		{d.sel_b, d.sel_a} = {6'($urandom_range(33)), 6'($urandom_range(33))};
		return d;
	endfunction
	initial begin
		{i_ce, i_reset, i_cfg_wr, i_assign_wr, i_cfg_contact, i_assign_data} = 15'h6000;
		i_cfg_data = '0;
		void'($urandom(90512));
		rnd_src();
		reset_model();
		repeat (4) @(negedge i_core_clk);
		i_reset = 1'b0;
		check_all();
		$display("test reset state done");
		repeat (8) begin
			rnd_src();
			check_all();
		end
		$display("test default inputs done");
		for (int c = 0; c < 34; c++) begin
			wr_cfg(2'h0, {3'h3, 18'h0, c[5:0], 4'h0, 1'h0});
			repeat (2) begin
				rnd_src();
				check_all();
			end
		end
		$display("test selector codes done");
		repeat (60) begin
			wr_cfg(2'($urandom), rnd_cfg());
			wr_cfg(2'($urandom), rnd_cfg());
			rnd_src();
			check_all();
		end
		$display("test functions and polarity done");
		repeat (12) begin
			for (int k = 0; k < 3; k++)
				m_map[k] = $urandom_range(5);
			i_assign_data = {3'(m_map[2]), 3'(m_map[1]), 3'(m_map[0])};
			i_assign_wr = 1'b1;
			@(negedge i_core_clk);
			i_assign_wr = 1'b0;
			wr_cfg(2'h1, {3'h3, 18'h0, 6'h20, 4'h0, 1'h0});
			rnd_src();
			check_all();
		end
		$display("test event assignment done");
		// outputs must hold the last settled values while the enable is low
		hold_c = {exp_con(2), exp_con(1), exp_con(0)};
		hold_e = exp_eo();
		i_ce = 1'b0;
		rnd_src();
		repeat (5) @(negedge i_core_clk);
		cmp(o_contact, hold_c, "frozen contact");
		cmp(o_evt_out, hold_e, "frozen event out");
		$display("test clock enable done");
		// reset still acts with the enable low
		i_reset = 1'b1;
		repeat (2) @(negedge i_core_clk);
		i_reset = 1'b0;
		i_ce = 1'b1;
		reset_model();
		check_all();
		$display("test second reset done");
		test_done();
	end
	initial begin
		#(40 * 20000);
		$display("ERROR %0t watchdog expired", $time);
		n_errors++;
		test_done();
	end
endmodule
